// ===== logic/ipb_defs.svh
// object dictionary constants of the interpolated position buffer block
`ifndef IPB_DEFS_SVH
`define IPB_DEFS_SVH

// object indices
`define IPB_IDX_TORQUE_OFFSET   16'h60B2
`define IPB_IDX_DATA_RECORD     16'h60C1
`define IPB_IDX_TIME_PERIOD     16'h60C2
`define IPB_IDX_DATA_CONFIG     16'h60C4

// subindices
`define IPB_SUB_HIGHEST         8'h00
`define IPB_SUB_FIRST_SETPOINT  8'h01
`define IPB_SUB_PERIOD_VALUE    8'h01
`define IPB_SUB_PERIOD_EXPONENT 8'h02
`define IPB_SUB_CAPACITY_MAX    8'h01
`define IPB_SUB_RECORDS_IN_USE  8'h02
`define IPB_SUB_ORGANISATION    8'h03
`define IPB_SUB_NEXT_FREE_SLOT  8'h04
`define IPB_SUB_RECORD_LENGTH   8'h05
`define IPB_SUB_CLEAR_COMMAND   8'h06

// highest subindex answers
`define IPB_HIGHEST_RECORD      8'h01
`define IPB_HIGHEST_PERIOD      8'h02
`define IPB_HIGHEST_CONFIG      8'h06

// reset values
`define IPB_RST_TORQUE_OFFSET   16'h0000
`define IPB_RST_SETPOINT        32'h0000_0000
`define IPB_RST_PERIOD_VALUE    8'h01
`define IPB_RST_PERIOD_EXPONENT 8'hFD
`define IPB_CAPACITY_MAX        32'h0000_0001
`define IPB_RST_RECORDS_IN_USE  32'h0000_0001
`define IPB_RST_ORGANISATION    8'h00
`define IPB_RST_NEXT_FREE_SLOT  16'h0001
`define IPB_RST_RECORD_LENGTH   8'h04

// command and mode codes
`define IPB_CLEAR_DISABLE       8'h00
`define IPB_CLEAR_ENABLE        8'h01
`define IPB_ORG_FIFO            8'h00
`define IPB_ORG_RING            8'h01

`endif

// ===== logic/ipb_pkg.sv
// types of the interpolated position buffer block
package ipb_pkg;

  // answer code of one object dictionary access
  typedef enum logic [1:0] {
    IPB_RESP_OK      = 2'b00,
    IPB_RESP_NO_OBJ  = 2'b01,
    IPB_RESP_ACCESS  = 2'b10,
    IPB_RESP_REFUSED = 2'b11
  } ipb_resp_t;

  // one object dictionary request
  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } ipb_od_req_t;

  // whole state of the top module
  typedef struct packed {
    logic [15:0] torque_setpoint_offset;
    logic [31:0] interp_first_setpoint;
    logic [7:0]  interp_period_value;
    logic [7:0]  interp_period_exponent;
    logic [31:0] buffer_records_in_use;
    logic [7:0]  buffer_organisation;
    logic        ring_mode;
    logic [15:0] buffer_next_free_slot;
    logic [7:0]  record_length_bytes;
    logic        access_enabled;
    logic [31:0] demand_position;
    logic        demand_strobe;
    logic [31:0] cycle_time_us;
    logic [2:0]  buffer_level;
    logic        ack;
    ipb_resp_t   resp;
    logic [31:0] rdata;
  } ipb_state_t;

endpackage

// ===== logic/ipb_top.sv
// interpolated position buffer: set-point fifo and object dictionary top
`timescale 1ns/1ps
//
// Summary of operation
// RQ1: signed torque offset, tenths percent, resets zero
// RQ2: signed 32-bit demand position set-point entry
// RQ3: new set-point adopted at next sync only
// RQ4: cycle time equals period times ten power exponent
// RQ5: master keeps exponent at minus three
// RQ6: capacity entry reads one, read only
// RQ7: records in use entry, read write, resets one
// RQ8: organisation zero fifo, one ring buffer
// RQ9: next free slot entry resets to one
// RQ10: write-only record length in bytes, default four
// RQ11: clear zero flushes buffer, disables access
// RQ12: clear one enables input buffer access
// RQ13: disabled access ignores set-points; slot advances on accept

// ********************************************************************
// set-point fifo
// ********************************************************************
module ipb_fifo
  import ipb_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // flush everything held
  input  wire logic             i_flush,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  // fill state
  output logic                  o_full,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // pointer width
  localparam int CW = $clog2(DEPTH + 1);                // count width
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);      // last slot index
  localparam logic [CW-1:0] FULL = CW'(DEPTH);          // full count
  // fifo state: storage, pointers, count
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } ipb_fifo_state_t;
  ipb_fifo_state_t s_q;  // registered state
  ipb_fifo_state_t s_d;  // next state
  logic            push; // word written this cycle
  logic            pop;  // word taken this cycle
  // handshakes; a pop in the same cycle frees room for a push when full
  assign o_full      = (s_q.cnt == FULL);
  assign o_count     = s_q.cnt;
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data  = s_q.mem[s_q.rd];
  assign o_in_ready  = !o_full || i_out_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign push        = i_in_valid && o_in_ready;
  // next state
  always_comb begin
    s_d = s_q;
    if (i_flush) begin
      // flush wins over any transfer in the same cycle
      s_d.wr  = '0;
      s_d.rd  = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wr] = i_in_data;
        s_d.wr          = (s_q.wr == LAST) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
        s_d.rd = (s_q.rd == LAST) ? '0 : s_q.rd + 1'b1;
      end
      case ({push, pop})
        2'b10:   s_d.cnt = s_q.cnt + 1'b1;
        2'b01:   s_d.cnt = s_q.cnt - 1'b1;
        default: s_d.cnt = s_q.cnt;
      endcase
    end
  end
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // ipb_fifo

// ********************************************************************
// object dictionary top
// ********************************************************************
module ipb_top
  import ipb_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // object dictionary access
  input  wire logic        I_OD_REQ,
  input  wire logic        I_OD_WRITE,
  input  wire logic [15:0] I_OD_INDEX,
  input  wire logic [7:0]  I_OD_SUBINDEX,
  input  wire logic [31:0] I_OD_WDATA,
  output logic             O_OD_ACK,
  output ipb_resp_t        O_OD_STATUS,
  output logic [31:0]      O_OD_RDATA,
  // synchronisation instant
  input  wire logic        I_SYNC,
  // values toward the motion control
  output logic [15:0]      O_TORQUE_OFFSET,
  output logic [31:0]      O_DEMAND_POSITION,
  output logic             O_DEMAND_STROBE,
  output logic [31:0]      O_CYCLE_TIME_US,
  output logic [7:0]       O_RECORD_BYTES,
  output logic             O_RING_MODE,
  output logic             O_ACCESS_ENABLED,
  output logic [2:0]       O_BUFFER_LEVEL
);
  `include "ipb_defs.svh"
  localparam int CW = $clog2(FIFO_DEPTH + 1);  // fifo count width
  ipb_state_t  s_q;        // registered state
  ipb_state_t  s_d;        // next state
  ipb_od_req_t od;         // bundled request
  logic        sp_write;   // set-point write seen this cycle
  logic        sp_push;    // set-point offered to the fifo
  logic        ring_drop;  // oldest record discarded in ring mode
  logic        fifo_pop;   // fifo drain request
  logic        fifo_flush; // clear command flushes the fifo
  logic        in_ready;   // fifo has room
  logic        out_valid;  // fifo holds a record
  logic [31:0] out_data;   // oldest record
  logic        fifo_full;  // fifo full
  logic [CW-1:0] fifo_cnt; // fifo fill count

  // cycle time in microseconds, out of range exponents give zero
  function automatic logic [31:0] cycle_us(input logic [7:0] per, input logic [7:0] ex);
    logic [31:0] scale;
    scale = 32'h0000_0000;
    case (ex)
      8'hFA:   scale = 32'h0000_0001;  // 1e-6
      8'hFB:   scale = 32'h0000_000A;  // 1e-5
      8'hFC:   scale = 32'h0000_0064;  // 1e-4
      8'hFD:   scale = 32'h0000_03E8;  // 1e-3, the required time base
      8'hFE:   scale = 32'h0000_2710;  // 1e-2
      8'hFF:   scale = 32'h0001_86A0;  // 1e-1
      8'h00:   scale = 32'h000F_4240;  // 1e0
      default: scale = 32'h0000_0000;  // time bases of 10 s and more, or below 1 us
    endcase
    return {24'h00_0000, per} * scale;
  endfunction
  // bundle the request pins
  assign od = '{req: I_OD_REQ, write: I_OD_WRITE, index: I_OD_INDEX,
                sub: I_OD_SUBINDEX, wdata: I_OD_WDATA};
  // set-point writes reach the fifo only while access is enabled
  assign sp_write = od.req && od.write && (od.index == `IPB_IDX_DATA_RECORD)
                    && (od.sub == `IPB_SUB_FIRST_SETPOINT);
  assign sp_push  = sp_write && s_q.access_enabled;  // RQ13

  // ring mode overwrites the oldest record instead of refusing
  assign ring_drop = sp_push && fifo_full
                     && (s_q.buffer_organisation == `IPB_ORG_RING);  // RQ8

  // records leave the fifo at a sync instant or when ring mode drops the oldest
  assign fifo_pop = I_SYNC || ring_drop;  // RQ3

  // clear command zero flushes the received data
  assign fifo_flush = od.req && od.write && (od.index == `IPB_IDX_DATA_CONFIG)
                      && (od.sub == `IPB_SUB_CLEAR_COMMAND)
                      && (od.wdata[7:0] == `IPB_CLEAR_DISABLE);  // RQ11

  // ********************************************************************
  // set-point buffer
  // ********************************************************************
  ipb_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_flush     (fifo_flush),
    .i_in_valid  (sp_push),
    .o_in_ready  (in_ready),
    .i_in_data   (od.wdata),
    .o_out_valid (out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (out_data),
    .o_full      (fifo_full),
    .o_count     (fifo_cnt)
  );

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    s_d               = s_q;
    s_d.ack           = 1'b0;
    s_d.resp          = IPB_RESP_OK;
    s_d.rdata         = 32'h0000_0000;
    s_d.demand_strobe = 1'b0;
    s_d.cycle_time_us = cycle_us(s_q.interp_period_value,
                                 s_q.interp_period_exponent);  // RQ4
    s_d.buffer_level  = 3'(fifo_cnt);

    // adopt the oldest record at the sync instant, hold when empty; a flush or a ring drop wins
    if (I_SYNC && out_valid && !ring_drop && !fifo_flush) begin
      s_d.demand_position = out_data;  // RQ3
      s_d.demand_strobe   = 1'b1;
    end

    if (od.req) begin
      s_d.ack = 1'b1;
      case (od.index)
        // torque offset variable
        `IPB_IDX_TORQUE_OFFSET: begin
          if (od.sub != 8'h00) begin
            s_d.resp = IPB_RESP_NO_OBJ;
          end else if (od.write) begin
            s_d.torque_setpoint_offset = od.wdata[15:0];  // RQ1
          end else begin
            s_d.rdata = {16'h0000, s_q.torque_setpoint_offset};  // RQ1
          end
        end
        // interpolation data record
        `IPB_IDX_DATA_RECORD: begin
          case (od.sub)
            `IPB_SUB_HIGHEST: begin
              if (od.write) s_d.resp = IPB_RESP_ACCESS;
              else s_d.rdata = {24'h00_0000, `IPB_HIGHEST_RECORD};
            end
            `IPB_SUB_FIRST_SETPOINT: begin
              if (!od.write) begin
                s_d.rdata = s_q.interp_first_setpoint;  // RQ2
              end else if (!s_q.access_enabled) begin
                s_d.resp = IPB_RESP_REFUSED;  // RQ13
              end else if (!in_ready && !ring_drop) begin
                s_d.resp = IPB_RESP_REFUSED;  // full fifo back-pressure
              end else begin
                s_d.interp_first_setpoint = od.wdata;  // RQ2
                s_d.buffer_next_free_slot = s_q.buffer_next_free_slot + 1'b1;  // RQ13
              end
            end
            default: s_d.resp = IPB_RESP_NO_OBJ;
          endcase
        end
        // interpolation time period record
        `IPB_IDX_TIME_PERIOD: begin
          case (od.sub)
            `IPB_SUB_HIGHEST: begin
              if (od.write) s_d.resp = IPB_RESP_ACCESS;
              else s_d.rdata = {24'h00_0000, `IPB_HIGHEST_PERIOD};
            end
            `IPB_SUB_PERIOD_VALUE: begin
              if (od.write) s_d.interp_period_value = od.wdata[7:0];  // RQ4
              else s_d.rdata = {24'h00_0000, s_q.interp_period_value};
            end
            `IPB_SUB_PERIOD_EXPONENT: begin
              // stored as given; the master keeps it at the ms base
              if (od.write) s_d.interp_period_exponent = od.wdata[7:0];  // RQ5
              else s_d.rdata = {24'h00_0000, s_q.interp_period_exponent};
            end
            default: s_d.resp = IPB_RESP_NO_OBJ;
          endcase
        end
        // interpolation data configuration record
        `IPB_IDX_DATA_CONFIG: begin
          case (od.sub)
            `IPB_SUB_HIGHEST: begin
              if (od.write) s_d.resp = IPB_RESP_ACCESS;
              else s_d.rdata = {24'h00_0000, `IPB_HIGHEST_CONFIG};
            end
            `IPB_SUB_CAPACITY_MAX: begin
              if (od.write) s_d.resp = IPB_RESP_ACCESS;  // RQ6
              else s_d.rdata = `IPB_CAPACITY_MAX;  // RQ6
            end
            `IPB_SUB_RECORDS_IN_USE: begin
              if (od.write) s_d.buffer_records_in_use = od.wdata;  // RQ7
              else s_d.rdata = s_q.buffer_records_in_use;  // RQ7
            end
            `IPB_SUB_ORGANISATION: begin
              if (od.write) s_d.buffer_organisation = od.wdata[7:0];  // RQ8
              else s_d.rdata = {24'h00_0000, s_q.buffer_organisation};
              s_d.ring_mode = (s_d.buffer_organisation == `IPB_ORG_RING);  // RQ8
            end
            `IPB_SUB_NEXT_FREE_SLOT: begin
              if (od.write) s_d.buffer_next_free_slot = od.wdata[15:0];  // RQ9
              else s_d.rdata = {16'h0000, s_q.buffer_next_free_slot};  // RQ9
            end
            `IPB_SUB_RECORD_LENGTH: begin
              if (od.write) s_d.record_length_bytes = od.wdata[7:0];  // RQ10
              else s_d.resp = IPB_RESP_ACCESS;  // RQ10
            end
            `IPB_SUB_CLEAR_COMMAND: begin
              if (!od.write) begin
                s_d.resp = IPB_RESP_ACCESS;
              end else if (od.wdata[7:0] == `IPB_CLEAR_DISABLE) begin
                // records erased, slot pointer back to its start
                s_d.access_enabled        = 1'b0;  // RQ11
                s_d.buffer_next_free_slot = `IPB_RST_NEXT_FREE_SLOT;  // RQ11
              end else if (od.wdata[7:0] == `IPB_CLEAR_ENABLE) begin
                s_d.access_enabled = 1'b1;  // RQ12
              end
              // other codes are accepted and have no effect
            end
            default: s_d.resp = IPB_RESP_NO_OBJ;
          endcase
        end
        default: s_d.resp = IPB_RESP_NO_OBJ;
      endcase
    end
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q.torque_setpoint_offset <= `IPB_RST_TORQUE_OFFSET;  // RQ1
      s_q.interp_first_setpoint  <= `IPB_RST_SETPOINT;
      s_q.interp_period_value    <= `IPB_RST_PERIOD_VALUE;  // RQ4
      s_q.interp_period_exponent <= `IPB_RST_PERIOD_EXPONENT;  // RQ5
      s_q.buffer_records_in_use  <= `IPB_RST_RECORDS_IN_USE;  // RQ7
      s_q.buffer_organisation    <= `IPB_RST_ORGANISATION;  // RQ8
      s_q.ring_mode              <= 1'b0;  // organisation resets to fifo
      s_q.buffer_next_free_slot  <= `IPB_RST_NEXT_FREE_SLOT;  // RQ9
      s_q.record_length_bytes    <= `IPB_RST_RECORD_LENGTH;  // RQ10
      s_q.access_enabled         <= 1'b0;  // clear command resets to zero
      s_q.demand_position        <= `IPB_RST_SETPOINT;
      s_q.demand_strobe          <= 1'b0;
      s_q.cycle_time_us          <= 32'h0000_03E8;  // matches reset period
      s_q.buffer_level           <= 3'h0;
      s_q.ack                    <= 1'b0;
      s_q.resp                   <= IPB_RESP_OK;
      s_q.rdata                  <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // outputs, all straight from the state register
  // ********************************************************************
  assign O_OD_ACK          = s_q.ack;
  assign O_OD_STATUS       = s_q.resp;
  assign O_OD_RDATA        = s_q.rdata;
  assign O_TORQUE_OFFSET   = s_q.torque_setpoint_offset;
  assign O_DEMAND_POSITION = s_q.demand_position;
  assign O_DEMAND_STROBE   = s_q.demand_strobe;
  assign O_CYCLE_TIME_US   = s_q.cycle_time_us;
  assign O_RECORD_BYTES    = s_q.record_length_bytes;
  assign O_RING_MODE       = s_q.ring_mode;
  assign O_ACCESS_ENABLED  = s_q.access_enabled;
  assign O_BUFFER_LEVEL    = s_q.buffer_level;

endmodule // ipb_top

// ===== verification/ipb_top_chk.sv
// concurrent checks on the ports of the interpolated position buffer
`timescale 1ns/1ps
`include "ipb_defs.svh"
module ipb_top_chk
  import ipb_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // object dictionary access
  input  wire logic        I_OD_REQ,
  input  wire logic        I_OD_WRITE,
  input  wire logic [15:0] I_OD_INDEX,
  input  wire logic [7:0]  I_OD_SUBINDEX,
  input  wire logic [31:0] I_OD_WDATA,
  input  wire logic        O_OD_ACK,
  input  wire ipb_resp_t   O_OD_STATUS,
  input  wire logic [31:0] O_OD_RDATA,
  // sync and outputs
  input  wire logic        I_SYNC,
  input  wire logic [15:0] O_TORQUE_OFFSET,
  input  wire logic [31:0] O_DEMAND_POSITION,
  input  wire logic        O_DEMAND_STROBE,
  input  wire logic        O_RING_MODE,
  input  wire logic        O_ACCESS_ENABLED,
  input  wire logic [2:0]  O_BUFFER_LEVEL
);
  // ******************************************************
  // decoded requests
  // ******************************************************
  logic wr_q;  // write request this cycle
  logic rd_q;  // read request this cycle
  logic cfg;   // addressed to the buffer configuration
  assign wr_q = I_OD_REQ & I_OD_WRITE;
  assign rd_q = I_OD_REQ & ~I_OD_WRITE;
  assign cfg  = (I_OD_INDEX == `IPB_IDX_DATA_CONFIG);
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // ******************************************************
  // assertions
  // ******************************************************
  AST_ACK_FOLLOWS: assert property (I_OD_REQ |=> O_OD_ACK)
    else $error("access not answered next cycle");
  AST_ACK_CAUSED: assert property (O_OD_ACK |-> $past(I_OD_REQ))
    else $error("answer without request");
  AST_TORQUE_WRITE: assert property (wr_q && I_OD_INDEX == `IPB_IDX_TORQUE_OFFSET
    && I_OD_SUBINDEX == 8'h00 |=> O_TORQUE_OFFSET == $past(I_OD_WDATA[15:0]))
    else $error("torque offset not taken");
  AST_STROBE_AT_SYNC: assert property (O_DEMAND_STROBE |-> $past(I_SYNC))
    else $error("demand adopted without sync");
  AST_POS_HELD: assert property ($changed(O_DEMAND_POSITION) |-> O_DEMAND_STROBE)
    else $error("demand moved outside adoption");
  AST_CAP_READONLY: assert property (wr_q && cfg && I_OD_SUBINDEX == 8'h01
    |=> O_OD_STATUS == IPB_RESP_ACCESS)
    else $error("capacity accepted a write");
  AST_WO_READ: assert property (rd_q && cfg && I_OD_SUBINDEX inside {8'h05, 8'h06}
    |=> O_OD_STATUS == IPB_RESP_ACCESS && O_OD_RDATA == 32'h0)
    else $error("write-only entry was readable");
  AST_RING_DECODE: assert property (wr_q && cfg && I_OD_SUBINDEX == 8'h03
    && I_OD_WDATA[7:1] == 7'h00 |=> O_RING_MODE == $past(I_OD_WDATA[0]))
    else $error("organisation not followed");
  AST_CLEAR_OFF: assert property (wr_q && cfg && I_OD_SUBINDEX == 8'h06
    && I_OD_WDATA[7:0] == 8'h00 |=> !O_ACCESS_ENABLED ##1 O_BUFFER_LEVEL == 3'h0)
    else $error("clear did not flush and lock");
  AST_CLEAR_ON: assert property (wr_q && cfg && I_OD_SUBINDEX == 8'h06
    && I_OD_WDATA[7:0] == 8'h01 |=> O_ACCESS_ENABLED)
    else $error("enable command ignored");
  AST_LOCKED_REFUSE: assert property (wr_q && I_OD_INDEX == `IPB_IDX_DATA_RECORD
    && I_OD_SUBINDEX == 8'h01 && !O_ACCESS_ENABLED |=> O_OD_STATUS == IPB_RESP_REFUSED)
    else $error("set-point taken while locked");
  AST_LEVEL_CAP: assert property (O_BUFFER_LEVEL <= FIFO_DEPTH)
    else $error("buffer level beyond depth");
endmodule // ipb_top_chk

bind ipb_top ipb_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .I_CLK, .I_RST_N, .I_OD_REQ, .I_OD_WRITE, .I_OD_INDEX, .I_OD_SUBINDEX, .I_OD_WDATA,
  .O_OD_ACK, .O_OD_STATUS, .O_OD_RDATA, .I_SYNC, .O_TORQUE_OFFSET, .O_DEMAND_POSITION,
  .O_DEMAND_STROBE, .O_RING_MODE, .O_ACCESS_ENABLED, .O_BUFFER_LEVEL
);

// ===== verification/ipb_master_model.sv
// fieldbus master model: sync instants and the time base it keeps
`timescale 1ns/1ps
module ipb_master_model
  import ipb_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // bench asks for one sync instant
  input  wire logic  i_fire,
  // toward the block
  output logic       o_sync,
  output logic [7:0] o_exponent
);
  // millisecond time base, this master never moves it
  assign o_exponent = 8'hFD;
  // sync leaves on a clock edge, one cycle wide, same clock as the block
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync <= 1'b0;
    end else begin
      o_sync <= i_fire;
    end
  end
endmodule // ipb_master_model

// ===== verification/ipb_top_tb.sv
// self-checking bench of the interpolated position buffer
`timescale 1ns/1ps
`include "ipb_defs.svh"
module ipb_top_tb
  import ipb_pkg::*;
;
  // short names of the objects
  localparam logic [15:0] TQ  = `IPB_IDX_TORQUE_OFFSET;
  localparam logic [15:0] REC = `IPB_IDX_DATA_RECORD;
  localparam logic [15:0] TP  = `IPB_IDX_TIME_PERIOD;
  localparam logic [15:0] CF  = `IPB_IDX_DATA_CONFIG;
  logic        clk, rst_n, od_req, od_write, fire, sync, ack, strobe, ring, acc_en;
  logic [15:0] od_index, torque;
  logic [7:0]  od_sub, rec_bytes, mm_exp;
  logic [31:0] od_wdata, rdata, pos, cyc;
  logic [2:0]  level;
  ipb_resp_t   status;
  int          bad_count, n_tests, i;
  // set-points, a negative and both extremes among them
  logic [31:0] pts [4] = '{32'hFFFF_FF00, 32'h0000_1234, 32'h7FFF_FFFF, 32'h8000_0000};
  always #5 clk = ~clk;
  ipb_top #(.FIFO_DEPTH(4)) u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_OD_REQ(od_req), .I_OD_WRITE(od_write),
    .I_OD_INDEX(od_index), .I_OD_SUBINDEX(od_sub), .I_OD_WDATA(od_wdata),
    .O_OD_ACK(ack), .O_OD_STATUS(status), .O_OD_RDATA(rdata), .I_SYNC(sync),
    .O_TORQUE_OFFSET(torque), .O_DEMAND_POSITION(pos), .O_DEMAND_STROBE(strobe),
    .O_CYCLE_TIME_US(cyc), .O_RECORD_BYTES(rec_bytes), .O_RING_MODE(ring),
    .O_ACCESS_ENABLED(acc_en), .O_BUFFER_LEVEL(level));
  ipb_master_model u_mm (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .o_sync(sync),
    .o_exponent(mm_exp));
  // ******************************************************
  // tasks
  // ******************************************************
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // one edge, inputs then move 1 ns later
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // one access: request for one edge, then the answer must stand
  task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] wd, input ipb_resp_t es, input logic [31:0] er);
    int n;
    od_req   = 1'b1;
    od_write = w;
    od_index = ix;
    od_sub   = sb;
    od_wdata = wd;
    tick();
    od_req = 1'b0;
    n = 0;
    // bounded wait, a hang ends the run
    while (ack !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    if (ack !== 1'b1) begin
      chk(1'b0, "no answer");
      close_out();
    end else begin
      chk(status === es && rdata === er, "access answer");
    end
    // one edge passes so the next request starts in a new time step
    tick();
  endtask
  // one sync instant via the master, strobe looked for each cycle
  task automatic syn(input logic es, input logic [31:0] ep);
    logic seen;
    fire = 1'b1;
    tick();
    fire = 1'b0;
    seen = 1'b0;
    repeat (4) begin
      tick();
      if (strobe === 1'b1) begin
        seen = 1'b1;
      end
    end
    chk(seen === es && pos === ep, "sync adoption");
  endtask
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    {clk, od_req, od_write, fire, rst_n} = 5'h00;
    {od_index, od_sub, od_wdata} = 56'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // reset values and access kinds
    acc(1'b0, TQ, 8'h00, 32'h0, IPB_RESP_OK, 32'h0);
    acc(1'b0, TP, 8'h01, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b0, TP, 8'h02, 32'h0, IPB_RESP_OK, 32'hFD);
    acc(1'b0, CF, 8'h01, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b0, CF, 8'h02, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b0, CF, 8'h03, 32'h0, IPB_RESP_OK, 32'h0);
    acc(1'b0, CF, 8'h04, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b0, CF, 8'h05, 32'h0, IPB_RESP_ACCESS, 32'h0);
    acc(1'b0, CF, 8'h06, 32'h0, IPB_RESP_ACCESS, 32'h0);
    chk(cyc === 32'h3E8 && rec_bytes === 8'h04 && acc_en === 1'b0, "reset outputs");
    // narrow write, upper bits ignored
    acc(1'b1, TQ, 8'h00, 32'hABCD_FF38, IPB_RESP_OK, 32'h0);
    acc(1'b0, TQ, 8'h00, 32'h0, IPB_RESP_OK, 32'h0000_FF38);
    chk(torque === 16'hFF38, "torque output");
    acc(1'b1, CF, 8'h02, 32'h5, IPB_RESP_OK, 32'h0);
    acc(1'b0, CF, 8'h02, 32'h0, IPB_RESP_OK, 32'h5);
    acc(1'b1, CF, 8'h05, 32'h8, IPB_RESP_OK, 32'h0);
    chk(rec_bytes === 8'h08, "record length");
    acc(1'b1, CF, 8'h01, 32'h7, IPB_RESP_ACCESS, 32'h0);
    acc(1'b0, CF, 8'h01, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b0, 16'h60C3, 8'h00, 32'h0, IPB_RESP_NO_OBJ, 32'h0);
    // cycle time: 2 ms at the master's base
    acc(1'b1, TP, 8'h02, {24'h0, mm_exp}, IPB_RESP_OK, 32'h0);
    acc(1'b1, TP, 8'h01, 32'h2, IPB_RESP_OK, 32'h0);
    tick();
    chk(cyc === 32'h7D0, "cycle time");
    // locked buffer refuses, slot stays
    acc(1'b1, REC, 8'h01, 32'h11, IPB_RESP_REFUSED, 32'h0);
    acc(1'b0, CF, 8'h04, 32'h0, IPB_RESP_OK, 32'h1);
    acc(1'b1, CF, 8'h06, 32'h1, IPB_RESP_OK, 32'h0);
    chk(acc_en === 1'b1, "access enabled");
    // fill until the fifo refuses; nothing adopted before sync
    for (i = 0; i < 4; i++) begin
      acc(1'b1, REC, 8'h01, pts[i], IPB_RESP_OK, 32'h0);
    end
    acc(1'b1, REC, 8'h01, 32'h99, IPB_RESP_REFUSED, 32'h0);
    acc(1'b0, CF, 8'h04, 32'h0, IPB_RESP_OK, 32'h5);
    chk(level === 3'h4 && pos === 32'h0, "full, not adopted");
    syn(1'b1, pts[0]);
    syn(1'b1, pts[1]);
    // ring mode: a write to a full buffer drops the oldest
    acc(1'b1, CF, 8'h03, 32'h1, IPB_RESP_OK, 32'h0);
    chk(ring === 1'b1, "ring mode");
    acc(1'b1, REC, 8'h01, 32'h55, IPB_RESP_OK, 32'h0);
    acc(1'b1, REC, 8'h01, 32'h66, IPB_RESP_OK, 32'h0);
    acc(1'b1, REC, 8'h01, 32'h77, IPB_RESP_OK, 32'h0);
    syn(1'b1, pts[3]);
    // clear: flush, lock, slot back to one, sync finds nothing
    acc(1'b1, CF, 8'h06, 32'h0, IPB_RESP_OK, 32'h0);
    tick();
    chk(acc_en === 1'b0 && level === 3'h0, "cleared");
    acc(1'b0, CF, 8'h04, 32'h0, IPB_RESP_OK, 32'h1);
    syn(1'b0, pts[3]);
    close_out();
  end
endmodule // ipb_top_tb
